// ==== pkg/dwd_pkg.sv ====
// Constants shared by the dual watchdog timeout logic.
// Functional notes
// R01: Prescale codes 0-5 divide 4..128, 6-7 divide 256
// R02: Twelve-bit reload value, full 0x000 to 0xfff range
// R03: Independent counter advances on low-speed oscillator edges
// R04: Oscillator-domain crossing adds up to one period
// R05: Timer base codes 0-3 give prescaler 1,2,4,8
// R06: Window timeout spans one to 64 ticks
// R07: Expire after reload+1 ticks; window tick 4096*prescale
package dwd_pkg;
   // ****************************************************
   // Independent watchdog
   // ****************************************************
   localparam int unsigned INDEPENDENT_WATCHDOG_CNT_W     = 12;      // Reload width
   localparam int unsigned INDEPENDENT_WATCHDOG_PS_W      = 8;       // Prescale counter
   localparam int unsigned INDEPENDENT_WATCHDOG_PR_W      = 3;       // Prescale select
   localparam logic [8:0]  INDEPENDENT_WATCHDOG_DIV_BASE  = 9'h004;  // Divide at code 0
   localparam logic [2:0]  INDEPENDENT_WATCHDOG_PR_MAX    = 3'h6;    // Codes above clamp
   localparam logic [11:0] INDEPENDENT_WATCHDOG_CNT_RST   = 12'hfff; // Counter reset
   // ****************************************************
   // Window watchdog
   // ****************************************************
   localparam int unsigned WINDOW_WATCHDOG_PS_W      = 15;      // Tick prescaler
   localparam logic [15:0] WINDOW_WATCHDOG_DIV_BASE  = 16'h1000;// Bus clock / 4096
   localparam int unsigned WINDOW_WATCHDOG_CNT_W     = 7;       // Countdown width
   localparam logic [6:0]  WINDOW_WATCHDOG_EXPIRE    = 7'h40;   // Last live value
   localparam logic [6:0]  WINDOW_WATCHDOG_CNT_RST   = 7'h7f;   // Counter reset
endpackage

// ==== src/dwd_sync.sv ====
// Two-stage synchroniser for an asynchronous level.
`timescale 1ns/1ps
module dwd_sync (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Level in and out
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;   // First stage, read only by second

   // ****************************************************
   // Two flip-flops in series
   // ****************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // dwd_sync

// ==== src/dwd_top.sv ====
// Timeout logic for the independent and window watchdogs.
`timescale 1ns/1ps
module dwd_top (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Low-speed oscillator pin
   input  wire logic        low_speed_osc,
   // Independent watchdog control
   input  wire logic        independent_watchdog_enable,
   input  wire logic [2:0]  independent_watchdog_prescale_select,
   input  wire logic [11:0] reload_value,
   input  wire logic        independent_watchdog_refresh,
   // Window watchdog control
   input  wire logic        window_watchdog_enable,
   input  wire logic [1:0]  window_timer_base,
   input  wire logic [6:0]  window_watchdog_load_value,
   input  wire logic        window_watchdog_refresh,
   // Status
   output logic [11:0]      independent_watchdog_count_q,
   output logic             independent_watchdog_timeout_q,
   output logic [6:0]       window_watchdog_count_q,
   output logic             window_watchdog_timeout_q
);
   // ****************************************************
   // Oscillator edge detection
   // ****************************************************
   logic osc_sync;     // Synchronised oscillator level
   logic osc_prev_q;   // Previous synchronised level
   logic osc_rise;     // One cycle per oscillator period

   // Oscillator passes two flops before any logic
   dwd_sync u_osc_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .async_in (low_speed_osc),
      .sync_out (osc_sync)
   );

   // Remember last level for the edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_prev_q <= 1'b0;
      end else begin
         osc_prev_q <= osc_sync;
      end
   end

   assign osc_rise = osc_sync & ~osc_prev_q; // R03

   // ****************************************************
   // Independent watchdog
   // ****************************************************
   logic [7:0]  independent_watchdog_ps_q;      // Oscillator edge prescaler
   logic [7:0]  independent_watchdog_ps_d;
   logic [11:0] independent_watchdog_cnt_d;     // Countdown next value
   logic        independent_watchdog_pend_q;    // Refresh waiting for an edge
   logic        independent_watchdog_pend_d;
   logic        independent_watchdog_tout_d;    // Timeout pulse next value
   logic [2:0]  independent_watchdog_sel;       // Clamped prescale code
   logic [8:0]  independent_watchdog_div;       // Divide ratio
   logic [7:0]  independent_watchdog_term;      // Last prescaler value
   logic        independent_watchdog_tick;      // One prescaled tick

   // Codes 6 and 7 both select divide-by-256
   always_comb begin
      independent_watchdog_sel  = (independent_watchdog_prescale_select >= dwd_pkg::INDEPENDENT_WATCHDOG_PR_MAX) ?
                  dwd_pkg::INDEPENDENT_WATCHDOG_PR_MAX : independent_watchdog_prescale_select; // R01
      independent_watchdog_div  = dwd_pkg::INDEPENDENT_WATCHDOG_DIV_BASE << independent_watchdog_sel; // R01
      independent_watchdog_term = 8'(independent_watchdog_div - 9'h001);
   end

   assign independent_watchdog_tick = independent_watchdog_enable & osc_rise & ~independent_watchdog_pend_q &
                      ~independent_watchdog_refresh & (independent_watchdog_ps_q >= independent_watchdog_term); // R03

   // Next state of prescaler, countdown and refresh
   always_comb begin
      independent_watchdog_ps_d   = independent_watchdog_ps_q;
      independent_watchdog_cnt_d  = independent_watchdog_count_q;
      independent_watchdog_pend_d = independent_watchdog_pend_q;
      independent_watchdog_tout_d = 1'b0;
      if (!independent_watchdog_enable) begin
         // Idle: hold the reload so start is clean
         independent_watchdog_ps_d   = 8'h00;
         independent_watchdog_cnt_d  = reload_value; // R02
         independent_watchdog_pend_d = 1'b0;
      end else if (osc_rise) begin
         if (independent_watchdog_pend_q || independent_watchdog_refresh) begin
            // Refresh lands only on an oscillator edge
            independent_watchdog_ps_d   = 8'h00; // R04
            independent_watchdog_cnt_d  = reload_value; // R04
            independent_watchdog_pend_d = 1'b0;
         end else if (independent_watchdog_tick) begin
            independent_watchdog_ps_d = 8'h00;
            if (independent_watchdog_count_q == 12'h000) begin
               // Tick at zero is the reload+1-th one
               independent_watchdog_tout_d = 1'b1; // R07
               independent_watchdog_cnt_d  = reload_value; // R02
            end else begin
               independent_watchdog_cnt_d = independent_watchdog_count_q - 12'h001; // R07
            end
         end else begin
            independent_watchdog_ps_d = independent_watchdog_ps_q + 8'h01;
         end
      end else if (independent_watchdog_refresh) begin
         // Between edges, park the refresh
         independent_watchdog_pend_d = 1'b1; // R04
      end
   end

   // Register the independent watchdog state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         independent_watchdog_ps_q      <= 8'h00;
         independent_watchdog_count_q   <= dwd_pkg::INDEPENDENT_WATCHDOG_CNT_RST;
         independent_watchdog_pend_q    <= 1'b0;
         independent_watchdog_timeout_q <= 1'b0;
      end else begin
         independent_watchdog_ps_q      <= independent_watchdog_ps_d;
         independent_watchdog_count_q   <= independent_watchdog_cnt_d;
         independent_watchdog_pend_q    <= independent_watchdog_pend_d;
         independent_watchdog_timeout_q <= independent_watchdog_tout_d;
      end
   end

   // ****************************************************
   // Window watchdog
   // ****************************************************
   logic [14:0] window_watchdog_ps_q;     // Bus clock prescaler
   logic [14:0] window_watchdog_ps_d;
   logic [6:0]  window_watchdog_cnt_d;    // Countdown next value
   logic        window_watchdog_tout_d;   // Timeout pulse next value
   logic [15:0] window_watchdog_div;      // 4096 times prescaler
   logic [14:0] window_watchdog_term;     // Last prescaler value
   logic        window_watchdog_tick;     // One window tick

   // Timer base code n gives prescaler 2**n
   always_comb begin
      window_watchdog_div  = dwd_pkg::WINDOW_WATCHDOG_DIV_BASE << window_timer_base; // R05
      window_watchdog_term = 15'(window_watchdog_div - 16'h0001); // R07
   end

   assign window_watchdog_tick = window_watchdog_enable & ~window_watchdog_refresh &
                      (window_watchdog_ps_q >= window_watchdog_term);

   // Next state of prescaler and countdown
   always_comb begin
      window_watchdog_ps_d   = window_watchdog_ps_q;
      window_watchdog_cnt_d  = window_watchdog_count_q;
      window_watchdog_tout_d = 1'b0;
      if (!window_watchdog_enable) begin
         window_watchdog_ps_d  = 15'h0000;
         window_watchdog_cnt_d = window_watchdog_load_value;
      end else if (window_watchdog_refresh) begin
         // Refresh restarts the tick as well
         window_watchdog_ps_d  = 15'h0000;
         window_watchdog_cnt_d = window_watchdog_load_value;
      end else if (window_watchdog_tick) begin
         window_watchdog_ps_d = 15'h0000;
         if (window_watchdog_count_q[6]) begin
            // Live while the top bit stands
            window_watchdog_cnt_d = window_watchdog_count_q - 7'h01; // R06
            if (window_watchdog_count_q == dwd_pkg::WINDOW_WATCHDOG_EXPIRE) begin
               window_watchdog_tout_d = 1'b1; // R06
            end
         end
      end else begin
         window_watchdog_ps_d = window_watchdog_ps_q + 15'h0001;
      end
   end

   // Register the window watchdog state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         window_watchdog_ps_q      <= 15'h0000;
         window_watchdog_count_q   <= dwd_pkg::WINDOW_WATCHDOG_CNT_RST;
         window_watchdog_timeout_q <= 1'b0;
      end else begin
         window_watchdog_ps_q      <= window_watchdog_ps_d;
         window_watchdog_count_q   <= window_watchdog_cnt_d;
         window_watchdog_timeout_q <= window_watchdog_tout_d;
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_independent_watchdog_div;
      (independent_watchdog_prescale_select[2:1] == 2'b11) |-> (independent_watchdog_term == 8'hff);
   endproperty
   a_independent_watchdog_div: assert property (p_independent_watchdog_div) // R01
      else $error("Prescale codes 6/7 not divide-by-256");

   property p_independent_watchdog_expire;
      independent_watchdog_timeout_q |-> ($past(independent_watchdog_count_q) == 12'h000) &&
                         (independent_watchdog_count_q == $past(reload_value));
   endproperty
   a_independent_watchdog_expire: assert property (p_independent_watchdog_expire) // R02
      else $error("Independent timeout not from zero count");

   property p_independent_watchdog_edge;
      independent_watchdog_tick |-> osc_sync && !osc_prev_q;
   endproperty
   a_independent_watchdog_edge: assert property (p_independent_watchdog_edge) // R03
      else $error("Independent tick without oscillator edge");

   // A refresh between edges is parked for the next edge
   property p_independent_watchdog_pend;
      (independent_watchdog_enable && independent_watchdog_refresh && !osc_rise) |=> independent_watchdog_pend_q;
   endproperty
   a_independent_watchdog_pend: assert property (p_independent_watchdog_pend) // R04
      else $error("Refresh lost before oscillator edge");

   // A parked or live refresh reloads on the oscillator edge
   property p_independent_watchdog_apply;
      (independent_watchdog_enable && osc_rise && (independent_watchdog_pend_q || independent_watchdog_refresh)) |=>
         (independent_watchdog_count_q == $past(reload_value)) && !independent_watchdog_timeout_q;
   endproperty
   a_independent_watchdog_apply: assert property (p_independent_watchdog_apply) // R04
      else $error("Parked refresh not applied at oscillator edge");

   property p_window_watchdog_base;
      (window_timer_base == 2'h3) |-> (window_watchdog_term == 15'h7fff);
   endproperty
   a_window_watchdog_base: assert property (p_window_watchdog_base) // R05
      else $error("Timer base 3 not prescaler 8");

   property p_window_watchdog_expire;
      window_watchdog_timeout_q |-> ($past(window_watchdog_count_q) == 7'h40) &&
                         (window_watchdog_count_q == 7'h3f);
   endproperty
   a_window_watchdog_expire: assert property (p_window_watchdog_expire) // R06
      else $error("Window timeout not at 0x40 to 0x3f");

   property p_independent_watchdog_step;
      (independent_watchdog_tick && independent_watchdog_count_q != 12'h000) |=>
         (independent_watchdog_count_q == $past(independent_watchdog_count_q) - 12'h001) &&
         !independent_watchdog_timeout_q;
   endproperty
   a_independent_watchdog_step: assert property (p_independent_watchdog_step) // R07
      else $error("Independent countdown step wrong");

   property p_window_watchdog_hold;
      (window_watchdog_enable && !window_watchdog_refresh && !window_watchdog_tick) |=>
         $stable(window_watchdog_count_q);
   endproperty
   a_window_watchdog_hold: assert property (p_window_watchdog_hold) // R07
      else $error("Window count moved without a tick");
endmodule // dwd_top

// ==== tb/tb_top.sv ====
// Self-checking testbench for the dual watchdog timeout logic.
`timescale 1ns/1ps
module tb_top;
   // ****************************************************
   // Stimulus and status
   // ****************************************************
   logic        ref_clk              = 1'b0;
   logic        rst_n                = 1'b0;
   logic        low_speed_osc        = 1'b0;
   logic        independent_watchdog_enable          = 1'b0;
   logic [2:0]  independent_watchdog_prescale_select = 3'h0;
   logic [11:0] reload_value         = 12'h000;
   logic        independent_watchdog_refresh         = 1'b0;
   logic        window_watchdog_enable          = 1'b0;
   logic [1:0]  window_timer_base    = 2'h0;
   logic [6:0]  window_watchdog_load_value      = 7'h40;
   logic        window_watchdog_refresh         = 1'b0;
   logic [11:0] independent_watchdog_count_q;
   logic        independent_watchdog_timeout_q;
   logic [6:0]  window_watchdog_count_q;
   logic        window_watchdog_timeout_q;
   int          n_errors             = 0;
   int          check_count          = 0;
   int          osc_half             = 4;  // Half period in ref_clk cycles
   int          osc_cnt              = 0;
   int          rises                = 0;  // Oscillator rising edges

   always #12.5 ref_clk = ~ref_clk;

   // Oscillator model, rate set per scenario
   always @(posedge ref_clk) begin
      if (osc_cnt >= osc_half - 1) begin
         osc_cnt       <= 0;
         low_speed_osc <= ~low_speed_osc;
         if (!low_speed_osc) begin
            rises <= rises + 1;
         end
      end else begin
         osc_cnt <= osc_cnt + 1;
      end
   end

   dwd_top i_dut (
      .ref_clk              (ref_clk),
      .rst_n                (rst_n),
      .low_speed_osc        (low_speed_osc),
      .independent_watchdog_enable          (independent_watchdog_enable),
      .independent_watchdog_prescale_select (independent_watchdog_prescale_select),
      .reload_value         (reload_value),
      .independent_watchdog_refresh         (independent_watchdog_refresh),
      .window_watchdog_enable          (window_watchdog_enable),
      .window_timer_base    (window_timer_base),
      .window_watchdog_load_value      (window_watchdog_load_value),
      .window_watchdog_refresh         (window_watchdog_refresh),
      .independent_watchdog_count_q         (independent_watchdog_count_q),
      .independent_watchdog_timeout_q       (independent_watchdog_timeout_q),
      .window_watchdog_count_q         (window_watchdog_count_q),
      .window_watchdog_timeout_q       (window_watchdog_timeout_q)
   );

   // ****************************************************
   // Shared tasks
   // ****************************************************
   // Compare and count
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Verdict and end of run
   task automatic report_and_stop;
      if (n_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Independent countdown: count oscillator edges up to expiry
   task automatic independent_watchdog_run(logic [2:0] pr, logic [11:0] rl, int half);
      int div;
      int start;
      int n;
      int got;
      div = (pr >= 3'h6) ? 256 : (4 << pr);
      @(posedge ref_clk);
      osc_half             = half;
      independent_watchdog_enable          <= 1'b0;
      independent_watchdog_prescale_select <= pr;
      reload_value         <= rl;
      repeat (4) @(negedge ref_clk);
      chk("independent_watchdog_count_q idle", {20'h0, rl}, {20'h0, independent_watchdog_count_q});
      @(posedge ref_clk);
      independent_watchdog_enable <= 1'b1;
      start = rises;
      n = 0;
      while (independent_watchdog_timeout_q !== 1'b1 && n < 40000) begin
         @(negedge ref_clk);
         n++;
      end
      got = rises - start;
      // One oscillator period of phase uncertainty is allowed
      if (got == (rl + 1) * div - 1 || got == (rl + 1) * div + 1) begin
         got = (rl + 1) * div;
      end
      chk("independent_watchdog edges to expiry", (rl + 1) * div, got);
      chk("independent_watchdog_count_q reload", {20'h0, rl}, {20'h0, independent_watchdog_count_q});
      @(negedge ref_clk);
      chk("independent_watchdog_timeout_q pulse", 32'h0, {31'h0, independent_watchdog_timeout_q});
   endtask

   // Refresh mid-countdown restores the reload value
   task automatic independent_watchdog_refresh_chk;
      repeat (40) @(posedge ref_clk);
      independent_watchdog_refresh <= 1'b1;
      @(posedge ref_clk);
      independent_watchdog_refresh <= 1'b0;
      repeat (20) @(negedge ref_clk);
      chk("independent_watchdog_count_q refresh", 32'h3, {20'h0, independent_watchdog_count_q});
   endtask

   // Window countdown from 0x40 to expiry at each timer base
   task automatic window_watchdog_run(logic [1:0] tb);
      int n;
      @(posedge ref_clk);
      window_watchdog_enable       <= 1'b0;
      window_timer_base <= tb;
      @(posedge ref_clk);
      window_watchdog_enable  <= 1'b1;
      window_watchdog_refresh <= 1'b1;
      @(posedge ref_clk);
      window_watchdog_refresh <= 1'b0;
      repeat ((4096 << tb) - 8) @(negedge ref_clk);
      chk("window_watchdog_count_q early", 32'h40, {25'h0, window_watchdog_count_q});
      n = 0;
      while (window_watchdog_timeout_q !== 1'b1 && n < 16) begin
         @(negedge ref_clk);
         n++;
      end
      chk("window_watchdog_timeout_q", 32'h1, {31'h0, window_watchdog_timeout_q});
      chk("window_watchdog_count_q expiry", 32'h3f, {25'h0, window_watchdog_count_q});
      @(negedge ref_clk);
      chk("window_watchdog_timeout_q pulse", 32'h0, {31'h0, window_watchdog_timeout_q});
      if (tb == 2'h0) begin
         repeat (4200) @(negedge ref_clk);
         chk("window_watchdog_count_q hold", 32'h3f, {25'h0, window_watchdog_count_q});
      end
   endtask

   // ****************************************************
   // Main sequence
   // ****************************************************
   initial begin
      repeat (5) @(negedge ref_clk);
      chk("independent_watchdog_count_q reset", 32'hfff, {20'h0, independent_watchdog_count_q});
      chk("window_watchdog_count_q reset", 32'h7f, {25'h0, window_watchdog_count_q});
      @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      // Full-range countdown on the fastest oscillator, beside the
      // window scenarios, keeps the run short
      fork
         independent_watchdog_run(3'h0, 12'hfff, 1);
         for (int t = 0; t < 4; t++) begin
            window_watchdog_run(t[1:0]);
         end
      join
      for (int p = 0; p < 8; p++) begin
         independent_watchdog_run(p[2:0], 12'h001, 4);
      end
      independent_watchdog_run(3'h0, 12'h003, 4);
      independent_watchdog_refresh_chk();
      independent_watchdog_run(3'h0, 12'h000, 333);
      independent_watchdog_run(3'h0, 12'h000, 667);
      report_and_stop();
   end

   // Hang guard, some margin above the roughly 88000 cycles needed
   initial begin
      #2400000;
      n_errors++;
      report_and_stop();
   end
endmodule // tb_top
